// File: logic/pcatb_pkg.sv
// package for the counter array timebase: field layouts, reset values, timebase codes
// assumes a single 25 MHz system clock domain
package pcatb_pkg;

  // =====================================================================
  // timebase select codes
  typedef enum logic [2:0] {
    PCATB_SYS_DIV12 = 3'h0,
    PCATB_SYS_DIV4  = 3'h1,
    PCATB_T0_OVF    = 3'h2,
    PCATB_EXT_EDGE  = 3'h3,
    PCATB_SYS       = 3'h4,
    PCATB_XOSC_DIV8 = 3'h5,
    PCATB_RSVD6     = 3'h6,
    PCATB_RSVD7     = 3'h7
  } pcatb_tbsel_t;

  // =====================================================================
  // widths, divisors and reset values
  localparam int          PCATB_CNT_W      = 16;
  localparam int          PCATB_BYTE_W     = 8;
  localparam int          PCATB_NUM_MOD    = 5;
  localparam logic [3:0]  PCATB_DIV12_LAST = 4'hB;
  localparam logic [1:0]  PCATB_DIV4_LAST  = 2'h3;
  localparam logic [2:0]  PCATB_XDIV8_HALF = 3'h3;
  localparam logic [15:0] PCATB_CNT_RST    = 16'h0000;
  localparam logic [15:0] PCATB_CNT_MAX    = 16'hFFFF;
  localparam logic [7:0]  PCATB_SNAP_RST   = 8'h00;
  localparam logic        PCATB_WDT_RST    = 1'b1;

  // =====================================================================
  // mode bits as one carrier
  typedef struct packed {
    logic         idle_suspend;
    pcatb_tbsel_t timebase_select;
    logic         overflow_irq_enable;
  } pcatb_mode_t;

  // software access strobes to the counter bytes and flag
  typedef struct packed {
    logic       rd_low;
    logic       rd_high;
    logic       wr_low;
    logic       wr_high;
    logic [7:0] wdata;
    logic       clr_flag;
  } pcatb_acc_t;

endpackage

// File: logic/pcatb_timebase.sv
// 16-bit counter array timebase with snapshot read and overflow flag
// assumes access strobes come from logic on MCLK; pins arrive asynchronously
//
// What this block does
// RULE_01: one 16-bit up-counter that software sees as a low byte and a high byte register.
// RULE_02: reading the low byte latches the high byte into a snapshot that the next high read returns.
// RULE_03: reads of either byte never disturb counting.
// RULE_04: a wrap from 0xFFFF to 0x0000 sets the overflow flag.
// RULE_05: an interrupt request is raised while the flag and the overflow enable are both one.
// RULE_06: the flag is only cleared by software, never by servicing the interrupt.
// RULE_07: the processor sees the request only when global and array enables are both set; IRQ here ignores both and the interrupt controller applies them.
// RULE_08: with idle suspend clear the counter keeps running in processor idle.
// RULE_09: the timebase select picks clk/12, clk/4, timer 0 overflow, external edges, clk, or xosc/8.
// RULE_10: external input advances on falling edges, at most a quarter of the clock rate.
// RULE_11: the external oscillator divided by eight is resynchronised before use.
// RULE_12: the count feeds five capture/compare modules as their common time reference.
// RULE_13: after reset module 4 is in watchdog mode and some register writes are blocked.
// RULE_14: with idle suspend set the counter holds while the processor is idle.
// RULE_15: the external input is synchronised and falling edges found from successive samples.
// RULE_16: reserved timebase codes stop the counter.
`timescale 1ns/1ps
module pcatb_timebase
  import pcatb_pkg::*;
(
  // clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     RST_N,
  // configuration and access
  input  wire pcatb_mode_t              MODE,
  input  wire pcatb_acc_t               ACC,
  input  wire logic                     CPU_IDLE,
  input  wire logic                     WDT_DISABLE,
  // timebase sources
  input  wire logic                     T0_OVF,
  input  wire logic                     EXT_COUNT_IN,
  input  wire logic                     XOSC_CLK_IN,
  // read data and status
  output logic [7:0]                    RDATA,
  output logic                          OVERFLOW_FLAG,
  output logic                          IRQ,
  output logic                          WATCHDOG_MODE,
  output logic [15:0]                   TIME_REF [PCATB_NUM_MOD]
);

  // =====================================================================
  // state
  logic [15:0] count;
  logic [7:0]  snapshot;
  logic [3:0]  div12;
  logic [1:0]  div4;
  logic [1:0]  eci_sync;
  logic        eci_prev;
  logic [1:0]  xosc_sync;
  logic        xosc_prev;
  logic [2:0]  xosc_div;
  logic        tick;
  logic        run;
  logic        eci_fall;
  logic        xosc_rise;
  logic        wrap;

  // =====================================================================
  // prescalers on the system clock
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div12 <= 4'h0;
    end else if (div12 == PCATB_DIV12_LAST) begin
      div12 <= 4'h0;
    end else begin
      div12 <= div12 + 4'h1;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      div4 <= 2'h0;
    end else begin
      div4 <= div4 + 2'h1;
    end
  end

  // =====================================================================
  // external count input: two-flop sync then falling-edge compare
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      eci_sync <= 2'h3;
      eci_prev <= 1'b1;
    end else begin
      eci_sync <= {eci_sync[0], EXT_COUNT_IN};  // [RULE_15]
      eci_prev <= eci_sync[1];
    end
  end
  assign eci_fall = eci_prev & ~eci_sync[1];  // [RULE_10] [RULE_15]

  // =====================================================================
  // external oscillator: sampled on mclk, divided by eight here
  // sampling limits the oscillator to below half of MCLK; the usual case is a slow crystal
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      xosc_sync <= 2'h0;
      xosc_prev <= 1'b0;
    end else begin
      xosc_sync <= {xosc_sync[0], XOSC_CLK_IN};  // [RULE_11]
      xosc_prev <= xosc_sync[1];
    end
  end
  assign xosc_rise = xosc_sync[1] & ~xosc_prev;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      xosc_div <= 3'h0;
    end else if (xosc_rise) begin
      xosc_div <= xosc_div + 3'h1;
    end
  end

  // =====================================================================
  // timebase selection
  always_comb begin
    case (MODE.timebase_select)  // [RULE_09]
      PCATB_SYS_DIV12: tick = (div12 == PCATB_DIV12_LAST);
      PCATB_SYS_DIV4:  tick = (div4 == PCATB_DIV4_LAST);
      PCATB_T0_OVF:    tick = T0_OVF;
      PCATB_EXT_EDGE:  tick = eci_fall;
      PCATB_SYS:       tick = 1'b1;
      PCATB_XOSC_DIV8: tick = xosc_rise & (xosc_div == PCATB_XDIV8_HALF);  // [RULE_11]
      default:         tick = 1'b0;  // [RULE_16]
    endcase
  end

  // idle only stops counting when suspend is requested
  assign run  = tick & ~(CPU_IDLE & MODE.idle_suspend);  // [RULE_08] [RULE_14]
  assign wrap = run & (count == PCATB_CNT_MAX);

  // =====================================================================
  // the counter; software writes are refused while the watchdog is active
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      count <= PCATB_CNT_RST;
    end else if (ACC.wr_low && !WATCHDOG_MODE) begin  // [RULE_13]
      count <= {count[15:8], ACC.wdata};
    end else if (ACC.wr_high && !WATCHDOG_MODE) begin  // [RULE_13]
      count <= {ACC.wdata, count[7:0]};
    end else if (run) begin
      count <= count + 16'h0001;  // [RULE_01] [RULE_03]
    end
  end

  // =====================================================================
  // snapshot and read data
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      snapshot <= PCATB_SNAP_RST;
    end else if (ACC.rd_low) begin
      snapshot <= count[15:8];  // [RULE_02]
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (ACC.rd_low) begin
      RDATA <= count[7:0];  // [RULE_01]
    end else if (ACC.rd_high) begin
      RDATA <= snapshot;  // [RULE_02]
    end
  end

  // =====================================================================
  // overflow flag: set wins over a software clear in the same cycle
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      OVERFLOW_FLAG <= 1'b0;
    end else if (wrap) begin
      OVERFLOW_FLAG <= 1'b1;  // [RULE_04]
    end else if (ACC.clr_flag) begin
      OVERFLOW_FLAG <= 1'b0;  // [RULE_06]
    end
  end

  // global and array enables are applied by the interrupt controller
  assign IRQ = OVERFLOW_FLAG & MODE.overflow_irq_enable;  // [RULE_05] [RULE_07]

  // =====================================================================
  // watchdog mode comes up on any reset
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      WATCHDOG_MODE <= PCATB_WDT_RST;  // [RULE_13]
    end else if (WDT_DISABLE) begin
      WATCHDOG_MODE <= 1'b0;
    end
  end

  always_comb begin
    for (int i = 0; i < PCATB_NUM_MOD; i++) begin
      TIME_REF[i] = count;  // [RULE_12]
    end
  end

  // =====================================================================
  // checks
  AST_WRAP_SETS_FLAG: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_04]
    wrap |=> OVERFLOW_FLAG)
    else $error("overflow flag not set after wrap");

  AST_FLAG_STICKY: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_06]
    OVERFLOW_FLAG && !ACC.clr_flag |=> OVERFLOW_FLAG)
    else $error("overflow flag dropped without clear");

  AST_IRQ: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_05]
    IRQ == (OVERFLOW_FLAG && MODE.overflow_irq_enable))
    else $error("irq does not follow flag and enable");

  AST_SNAPSHOT: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_02]
    ACC.rd_low ##1 (ACC.rd_high && !ACC.rd_low) |=> RDATA == $past(count[15:8], 2))
    else $error("high read did not return snapshot");

  AST_COUNT_STEP: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_03]
    run && !ACC.wr_low && !ACC.wr_high |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance on tick");

  AST_RSVD_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_16]
    MODE.timebase_select[2:1] == 2'b11 && !ACC.wr_low && !ACC.wr_high |=> $stable(count))
    else $error("counter moved on reserved timebase");

  AST_IDLE_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_14]
    CPU_IDLE && MODE.idle_suspend && !ACC.wr_low && !ACC.wr_high |=> $stable(count))
    else $error("counter moved while suspended in idle");

  AST_SYS_RUN: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_08]
    MODE.timebase_select == PCATB_SYS && !MODE.idle_suspend |-> run)
    else $error("counter stalled with system clock timebase");

  AST_DIV12: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_09]
    MODE.timebase_select == PCATB_SYS_DIV12 && tick
    |=> (MODE.timebase_select != PCATB_SYS_DIV12 || !tick) [*8])
    else $error("divide by twelve ticked too soon");

  AST_ECI_EDGE: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_15]
    eci_fall |-> $past(EXT_COUNT_IN, 3) && !$past(EXT_COUNT_IN, 2))
    else $error("external edge without falling sample");

  AST_WDT_WRITE: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_13]
    WATCHDOG_MODE && !run |=> $stable(count))
    else $error("counter written while watchdog active");

  // read, write, flag, timebase and watchdog detail
  AST_RDATA_LOW: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_01]
    ACC.rd_low |=> RDATA == $past(count[7:0]))
    else $error("low read did not return live low byte");

  AST_SNAP_LATCH: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_02]
    ACC.rd_low |=> snapshot == $past(count[15:8]))
    else $error("snapshot not latched on low read");

  AST_RDATA_HOLD: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_02]
    !ACC.rd_low && !ACC.rd_high |=> $stable(RDATA))
    else $error("read data changed without a read");

  AST_READ_NO_DISTURB: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_03]
    run && (ACC.rd_low || ACC.rd_high) && !ACC.wr_low && !ACC.wr_high
    |=> count == $past(count) + 16'h0001)
    else $error("read disturbed counting");

  AST_WRITE_LOW: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_01]
    ACC.wr_low && !WATCHDOG_MODE |=> count[7:0] == $past(ACC.wdata))
    else $error("low byte write did not land");

  AST_WRITE_HIGH: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_01]
    ACC.wr_high && !ACC.wr_low && !WATCHDOG_MODE |=> count[15:8] == $past(ACC.wdata))
    else $error("high byte write did not land");

  AST_FLAG_ONLY_WRAP: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_04]
    !OVERFLOW_FLAG && !wrap |=> !OVERFLOW_FLAG)
    else $error("overflow flag set without a wrap");

  AST_WRAP_ZERO: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_04]
    wrap && !ACC.wr_low && !ACC.wr_high |=> count == PCATB_CNT_RST)
    else $error("counter did not wrap to zero");

  AST_FLAG_CLEAR: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_06]
    ACC.clr_flag && !wrap |=> !OVERFLOW_FLAG)
    else $error("software clear did not drop the flag");

  AST_DIV4: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_09]
    MODE.timebase_select == PCATB_SYS_DIV4 && tick
    |=> (MODE.timebase_select != PCATB_SYS_DIV4 || !tick) [*3])
    else $error("divide by four ticked too soon");

  AST_XOSC_GAP: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_11]
    MODE.timebase_select == PCATB_XOSC_DIV8 && tick
    |=> (MODE.timebase_select != PCATB_XOSC_DIV8 || !tick) [*8])
    else $error("oscillator timebase ticked too soon");

  AST_ECI_GAP: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_15]
    eci_fall |=> !eci_fall)
    else $error("external edges in back-to-back cycles");

  AST_WDT_STAYS_OFF: assert property (@(posedge MCLK) disable iff (!RST_N) // [RULE_13]
    !WATCHDOG_MODE |=> !WATCHDOG_MODE)
    else $error("watchdog mode returned without reset");

  COV_WRAP:     cover property (@(posedge MCLK) disable iff (!RST_N) wrap);
  COV_SNAP:     cover property (@(posedge MCLK) disable iff (!RST_N) ACC.rd_low ##1 ACC.rd_high);
  COV_ECI:      cover property (@(posedge MCLK) disable iff (!RST_N) eci_fall && run);
  COV_XOSC:     cover property (@(posedge MCLK) disable iff (!RST_N)
    MODE.timebase_select == PCATB_XOSC_DIV8 && run);
  COV_WDT_OFF:  cover property (@(posedge MCLK) disable iff (!RST_N) $fell(WATCHDOG_MODE));

endmodule

// File: testbench/pcatb_timebase_bench.sv
// self-checking bench for the counter array timebase, random and corner stimulus
// assumes pcatb_pkg is compiled first; assertions live in the design files
`timescale 1ns/1ps
module pcatb_timebase_bench;
  import pcatb_pkg::*;
  logic        MCLK, RST_N, CPU_IDLE, WDT_DISABLE, T0_OVF, EXT_COUNT_IN, XOSC_CLK_IN;
  pcatb_mode_t MODE;
  pcatb_acc_t  ACC;
  logic [7:0]  RDATA;
  logic        OVERFLOW_FLAG, IRQ, WATCHDOG_MODE;
  logic [15:0] TIME_REF [PCATB_NUM_MOD];
  logic [15:0] c0;
  int          n_fail, checked, n, i, k;
  integer      seed;
  logic [1:0]  irq_gate;

  pcatb_timebase pcatb_timebase_i (.MCLK(MCLK), .RST_N(RST_N), .MODE(MODE), .ACC(ACC),
    .CPU_IDLE(CPU_IDLE), .WDT_DISABLE(WDT_DISABLE), .T0_OVF(T0_OVF),
    .EXT_COUNT_IN(EXT_COUNT_IN), .XOSC_CLK_IN(XOSC_CLK_IN), .RDATA(RDATA),
    .OVERFLOW_FLAG(OVERFLOW_FLAG), .IRQ(IRQ), .WATCHDOG_MODE(WATCHDOG_MODE),
    .TIME_REF(TIME_REF));

  // ====================================================================
  // helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc_pulse(input logic [5:0] s, input logic [7:0] d);
    @(posedge MCLK) ACC <= '{s[5], s[4], s[3], s[2], d, s[0]};
    @(posedge MCLK) ACC <= '0;
  endtask
  task automatic set_mode(input logic [2:0] c, input logic sus, input logic ien);
    @(posedge MCLK) MODE <= '{sus, pcatb_tbsel_t'(c), ien};
  endtask
  // ticks expected from the clock-derived sources over a window of cyc cycles
  function automatic int sys_ticks(input logic [2:0] c, input int cyc);
    case (c)
      3'h0: return cyc / 12;
      3'h1: return cyc / 4;
      3'h4: return cyc;
      default: return 0;
    endcase
  endfunction
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ====================================================================
  // clock, reset, watchdog
  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end
  initial begin
    repeat (5000) @(posedge MCLK);
    n_fail++;
    final_report;
  end

  // ====================================================================
  // main sequence
  initial begin
    // count pin idles high so the falling-edge detector sees no edge after reset
    {RST_N, CPU_IDLE, WDT_DISABLE, T0_OVF, EXT_COUNT_IN, XOSC_CLK_IN} = 6'h02;
    irq_gate = 2'b00;
    MODE = '{1'b0, PCATB_RSVD6, 1'b0};
    ACC = '0;
    n_fail = 0;
    checked = 0;
    seed = 32'hD41A;
    repeat (8) @(posedge MCLK);
    RST_N <= 1'b1;
    // writes are locked out while watchdog mode is up
    acc_pulse(6'h08, 8'h5A);
    #1 chk(16'(WATCHDOG_MODE), 16'h1);
    chk(TIME_REF[0], 16'h0000);
    @(posedge MCLK) WDT_DISABLE <= 1'b1;
    @(posedge MCLK) WDT_DISABLE <= 1'b0;
    #1 chk(16'(WATCHDOG_MODE), 16'h0);
    acc_pulse(6'h08, 8'hFD);
    acc_pulse(6'h04, 8'hFF);
    #1 chk(TIME_REF[0], 16'hFFFD);
    $display("test write lock done");
    // wrap near the top sets a sticky flag
    set_mode(3'h4, 1'b0, 1'b1);
    repeat (8) @(posedge MCLK);
    #1 chk(16'(OVERFLOW_FLAG), 16'h1);
    chk(16'(IRQ), 16'h1);
    // software's global and array enables gate what the processor takes
    irq_gate = 2'b11;
    chk(16'(IRQ & irq_gate[1] & irq_gate[0]), 16'h1);
    irq_gate = 2'b01;
    chk(16'(IRQ & irq_gate[1] & irq_gate[0]), 16'h0);
    set_mode(3'h4, 1'b0, 1'b0);
    #1 chk(16'(IRQ), 16'h0);
    repeat (20) @(posedge MCLK);
    #1 chk(16'(OVERFLOW_FLAG), 16'h1);
    acc_pulse(6'h01, 8'h00);
    #1 chk(16'(OVERFLOW_FLAG), 16'h0);
    $display("test overflow done");
    // coherent read across a high-byte change, counter undisturbed
    acc_pulse(6'h08, 8'hF0);
    acc_pulse(6'h04, 8'h12);
    @(posedge MCLK) ACC <= '{1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0};
    #1 c0 = TIME_REF[0];
    @(posedge MCLK) ACC <= '0;
    #1 chk(16'(RDATA), 16'(c0[7:0]));
    repeat (40) @(posedge MCLK);
    acc_pulse(6'h10, 8'h00);
    #1 chk(16'(RDATA), 16'(c0[15:8]));
    chk(TIME_REF[0] - c0, 16'd43);
    for (i = 1; i < PCATB_NUM_MOD; i++) chk(TIME_REF[i], TIME_REF[0]);
    // back-to-back low then high read
    @(posedge MCLK) ACC <= '{1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0};
    #1 c0 = TIME_REF[0];
    @(posedge MCLK) ACC <= '{1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 1'b0};
    #1 chk(16'(RDATA), 16'(c0[7:0]));
    @(posedge MCLK) ACC <= '0;
    #1 chk(16'(RDATA), 16'(c0[15:8]));
    $display("test snapshot done");
    // every select code, with timer 0, the count pin and the oscillator held quiet
    for (k = 0; k < 8; k++) begin
      set_mode(3'(k), 1'b0, 1'b0);
      repeat (3) @(posedge MCLK);
      #1 c0 = TIME_REF[0];
      repeat (48) @(posedge MCLK);
      #1 chk(TIME_REF[0] - c0, 16'(sys_ticks(3'(k), 48)));
    end
    // timer 0 overflow pulses drawn at random
    set_mode(3'h2, 1'b0, 1'b0);
    n = 0;
    #1 c0 = TIME_REF[0];
    for (i = 0; i < 40; i++) begin
      k = $random(seed) & 1;
      n += k;
      @(posedge MCLK) T0_OVF <= k[0];
    end
    @(posedge MCLK) T0_OVF <= 1'b0;
    repeat (4) @(posedge MCLK);
    #1 chk(TIME_REF[0] - c0, 16'(n));
    // random number of falling edges on the count pin, three cycles a level
    set_mode(3'h3, 1'b0, 1'b0);
    n = 1 + ($random(seed) & 7);
    #1 c0 = TIME_REF[0];
    for (i = 0; i < 2 * n; i++) begin
      @(posedge MCLK) EXT_COUNT_IN <= ~EXT_COUNT_IN;
      repeat (2) @(posedge MCLK);
    end
    repeat (6) @(posedge MCLK);
    #1 chk(TIME_REF[0] - c0, 16'(n));
    // oscillator at one sixth of the clock, sixteen rising edges give two ticks
    set_mode(3'h5, 1'b0, 1'b0);
    #1 c0 = TIME_REF[0];
    for (i = 0; i < 32; i++) begin
      @(posedge MCLK) XOSC_CLK_IN <= ~XOSC_CLK_IN;
      repeat (2) @(posedge MCLK);
    end
    repeat (6) @(posedge MCLK);
    #1 chk(TIME_REF[0] - c0, 16'h2);
    $display("test timebase done");
    // idle with and without suspend
    set_mode(3'h4, 1'b1, 1'b0);
    @(posedge MCLK) CPU_IDLE <= 1'b1;
    repeat (3) @(posedge MCLK);
    #1 c0 = TIME_REF[0];
    repeat (20) @(posedge MCLK);
    #1 chk(TIME_REF[0] - c0, 16'h0);
    set_mode(3'h4, 1'b0, 1'b0);
    repeat (2) @(posedge MCLK);
    #1 c0 = TIME_REF[0];
    repeat (20) @(posedge MCLK);
    #1 chk(TIME_REF[0] - c0, 16'd20);
    $display("test idle done");
    final_report;
  end
endmodule
